// ==== rtl/rpis_defines.svh ====
// register map, field layout, reset values and key bytes of the pin select
`ifndef RPIS_DEFINES_SVH
`define RPIS_DEFINES_SVH

// -----------------------------------------------------------------------
// register word addresses
// -----------------------------------------------------------------------
`define RPIS_ADDR_W      7
`define RPIS_IN_BASE     7'h00
`define RPIS_OUT_BASE    7'h20
`define RPIS_OSC_ADDR    7'h40

// -----------------------------------------------------------------------
// fields
// -----------------------------------------------------------------------
`define RPIS_DATA_W      16
`define RPIS_SEL_W       6
`define RPIS_HI_LSB      8
`define RPIS_LO_LSB      0
`define RPIS_LOCK_BIT    6
`define RPIS_MASK_BOTH   16'h3F3F
`define RPIS_MASK_HI     16'h3F00
`define RPIS_MASK_LO     16'h003F
`define RPIS_MAX_PIN     6'h2B
`define RPIS_FN_NULL     6'h00

// -----------------------------------------------------------------------
// reset values and unlock keys
// -----------------------------------------------------------------------
`define RPIS_IN_RESET    16'h3F3F
`define RPIS_OUT_RESET   16'h0000
`define RPIS_KEY_FIRST   8'h46
`define RPIS_KEY_SECOND  8'h57

// -----------------------------------------------------------------------
// input register indices of the routed selections
// -----------------------------------------------------------------------
`define RPIS_IDX_INT1    0
`define RPIS_IDX_INT32   1
`define RPIS_IDX_INT4    2
`define RPIS_IDX_TMR32   3
`define RPIS_IDX_TMR54   4
`define RPIS_IDX_CAP21   7
`define RPIS_IDX_CAP43   8
`define RPIS_IDX_UART1   18

`endif

// ==== rtl/rpis_pkg.sv ====
// types shared by the pin select files
`default_nettype none

package rpis_pkg;
    // unlock key progress
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_GOT_SECOND
    } rpis_key_t;

    typedef logic [15:0] rpis_word_t;   // one register word
    typedef logic [5:0]  rpis_sel_t;    // one pin selection field
endpackage : rpis_pkg

`default_nettype wire

// ==== rtl/rpis_in_route.sv ====
// one peripheral input routed from a selected remappable pin
`timescale 1ns/100ps
`default_nettype none
`include "rpis_defines.svh"

module rpis_in_route #(
    parameter int PIN_N = 44
) (
    input  wire logic             sys_clk_i, // system clock
    input  wire logic             srst_i,    // sync reset, high
    input  wire logic [PIN_N-1:0] pins_i,    // synchronised pin levels
    input  wire logic [5:0]       sel_i,     // pin number selected
    output logic                  mapped_o   // routed level, registered
);
    logic nxt_mapped;   // next routed level
    logic mapped_ff;    // routed level

    // -------------------------------------------------------------------
    // selection
    // -------------------------------------------------------------------
    // numbers past the last pin leave the input tied low
    always_comb begin
        nxt_mapped = 1'b0;
        if (sel_i <= `RPIS_MAX_PIN && 32'(sel_i) < PIN_N) begin
            nxt_mapped = pins_i[sel_i];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mapped_ff <= 1'b0;
        end else begin
            mapped_ff <= nxt_mapped;
        end
    end

    assign mapped_o = mapped_ff;

    a_route_invalid: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (sel_i > `RPIS_MAX_PIN) |=> !mapped_o)
        else $error("invalid selection did not leave input low");

    a_route_pin: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        // a number past the last built pin is unmapped like one above 43
        (sel_i <= `RPIS_MAX_PIN && 32'(sel_i) < PIN_N) |=>
        (mapped_o == $past(pins_i[sel_i])))
        else $error("routed input does not follow selected pin");
endmodule : rpis_in_route

`default_nettype wire

// ==== rtl/rpis_top.sv ====
// remappable pin select: mapping registers, lock sequence and routing
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "rpis_defines.svh"

// Notes on behaviour
// - mapping writes only while lock bit clear
// - 21 input and 16 output mapping registers
// - six-bit input fields, reset all ones
// - unimplemented input bits read zero, ignore writes
// - field value n routes pin n
// - output field code picks driving peripheral
// - register 0 int1 high; register 1 int3/int2
// - register 2 holds int4 in low field
// - timer clock fields in registers 3, 4
// - capture fields in registers 7, 8
// - selection above 43 leaves input unmapped
// - locked writes complete but change nothing
// - lock resets clear and holds until changed
// - one-session bit blocks clearing after first lock
module rpis_top #(
    parameter int IN_N  = 21,   // input mapping registers
    parameter int OUT_N = 16,   // output mapping registers
    parameter int PIN_N = 44,   // remappable pins usable as inputs
    parameter int FN_N  = 64    // peripheral output function codes
) (
    input  wire logic              sys_clk_i,     // system clock, 20 MHz
    input  wire logic              srst_i,        // sync reset, high
    input  wire logic [6:0]        addr_i,        // register word address
    input  wire logic [15:0]       wdata_i,       // write data
    input  wire logic              wr_i,          // write strobe
    input  wire logic              rd_i,          // read strobe
    output logic      [15:0]       rdata_o,       // read data, next cycle
    input  wire logic              one_session_i, // single session config
    input  wire logic [PIN_N-1:0]  rp_pin_i,      // remappable pin levels
    input  wire logic [FN_N-1:0]   periph_out_i,  // peripheral outputs
    output logic      [13:0]       periph_in_o,   // routed peripheral inputs
    output logic [2*OUT_N-1:0]     rp_pin_out_o,  // pin output levels
    output logic [2*OUT_N-1:0]     rp_pin_oe_o,   // pin output enables
    output logic                   mapping_lock_o // mapping lock bit
);
    // -------------------------------------------------------------------
    // elaboration checks
    // -------------------------------------------------------------------
    // index 18 must exist for the uart fields; addresses leave 32 and 16
    if (IN_N < 19 || IN_N > 32) begin : g_bad_in
        $error("IN_N must lie in 19..32");
    end
    if (OUT_N < 1 || OUT_N > 16) begin : g_bad_out
        $error("OUT_N must lie in 1..16");
    end
    if (PIN_N < 1 || PIN_N > 64 || FN_N != 64) begin : g_bad_pin
        $error("PIN_N must lie in 1..64 and FN_N be 64");
    end

    // -------------------------------------------------------------------
    // functions
    // -------------------------------------------------------------------
    // implemented bits of an input register; the rest read zero
    function automatic rpis_pkg::rpis_word_t field_mask(input int idx);
        case (idx)
            `RPIS_IDX_INT1: field_mask = `RPIS_MASK_HI;
            `RPIS_IDX_INT4: field_mask = `RPIS_MASK_LO;
            default:        field_mask = `RPIS_MASK_BOTH;
        endcase
    endfunction : field_mask

    // one field of a register word
    function automatic rpis_pkg::rpis_sel_t field(
        input rpis_pkg::rpis_word_t w,
        input logic                 hi
    );
        field = hi ? w[`RPIS_HI_LSB +: `RPIS_SEL_W]
                   : w[`RPIS_LO_LSB +: `RPIS_SEL_W];
    endfunction : field

    // -------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------
    logic       in_hit;    // address in input register range
    logic       out_hit;   // address in output register range
    logic       osc_hit;   // address is oscillator control
    logic [4:0] in_idx;    // input register index
    logic [3:0] out_idx;   // output register index
    logic [6:0] out_off;   // offset into output range

    assign out_off = addr_i - `RPIS_OUT_BASE;
    assign in_idx  = addr_i[4:0];
    assign out_idx = out_off[3:0];
    assign in_hit  = 32'(addr_i) < IN_N;
    assign out_hit = addr_i >= `RPIS_OUT_BASE && 32'(out_off) < OUT_N;
    assign osc_hit = addr_i == `RPIS_OSC_ADDR;

    // -------------------------------------------------------------------
    // pin synchronisers
    // -------------------------------------------------------------------
    // pins are asynchronous; only the second stage is read
    logic [PIN_N-1:0] pin_s1_ff;   // first stage
    logic [PIN_N-1:0] pin_s2_ff;   // second stage
    logic             cfg_s1_ff;   // config first stage
    logic             cfg_s2_ff;   // config second stage

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            cfg_s1_ff <= 1'b0;
            cfg_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff <= rp_pin_i;
            pin_s2_ff <= pin_s1_ff;
            cfg_s1_ff <= one_session_i;
            cfg_s2_ff <= cfg_s1_ff;
        end
    end

    // -------------------------------------------------------------------
    // lock sequence
    // -------------------------------------------------------------------
    rpis_pkg::rpis_key_t key_ff;     // key progress
    rpis_pkg::rpis_key_t nxt_key;
    logic                lock_ff;    // mapping lock bit
    logic                nxt_lock;
    logic                once_ff;    // lock has been set since reset
    logic                nxt_once;

    // any write other than the next key drops the sequence, except a repeated first key, which keeps it
    always_comb begin
        nxt_key  = key_ff;
        nxt_lock = lock_ff;
        nxt_once = once_ff | lock_ff;
        if (wr_i && !osc_hit) begin
            nxt_key = rpis_pkg::KEY_IDLE;
        end else if (wr_i) begin
            case (key_ff)
                rpis_pkg::KEY_IDLE: begin
                    if (wdata_i[7:0] == `RPIS_KEY_FIRST) begin
                        nxt_key = rpis_pkg::KEY_GOT_FIRST;
                    end
                end
                rpis_pkg::KEY_GOT_FIRST: begin
                    if (wdata_i[7:0] == `RPIS_KEY_SECOND) begin
                        nxt_key = rpis_pkg::KEY_GOT_SECOND;
                    end else if (wdata_i[7:0] != `RPIS_KEY_FIRST) begin
                        nxt_key = rpis_pkg::KEY_IDLE;
                    end
                end
                rpis_pkg::KEY_GOT_SECOND: begin
                    // the bit write itself ends the sequence
                    nxt_key = rpis_pkg::KEY_IDLE;
                    if (!(cfg_s2_ff && once_ff && !wdata_i[`RPIS_LOCK_BIT])) begin
                        nxt_lock = wdata_i[`RPIS_LOCK_BIT];
                    end
                end
                default: nxt_key = rpis_pkg::KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            key_ff  <= rpis_pkg::KEY_IDLE;
            lock_ff <= 1'b0;
            once_ff <= 1'b0;
        end else begin
            key_ff  <= nxt_key;
            lock_ff <= nxt_lock;
            once_ff <= nxt_once;
        end
    end

    // -------------------------------------------------------------------
    // mapping registers
    // -------------------------------------------------------------------
    logic [IN_N-1:0][15:0]  in_ff;     // input mapping registers
    logic [IN_N-1:0][15:0]  nxt_in;
    logic [OUT_N-1:0][15:0] out_ff;    // output mapping registers
    logic [OUT_N-1:0][15:0] nxt_out;

    // locked writes are accepted on the bus and dropped here
    always_comb begin
        nxt_in  = in_ff;
        nxt_out = out_ff;
        if (wr_i && !lock_ff) begin
            if (in_hit) begin
                nxt_in[in_idx] = wdata_i & field_mask(32'(in_idx));
            end
            if (out_hit) begin
                nxt_out[out_idx] = wdata_i & `RPIS_MASK_BOTH;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < IN_N; i++) begin
                in_ff[i] <= `RPIS_IN_RESET & field_mask(i);
            end
            for (int i = 0; i < OUT_N; i++) begin
                out_ff[i] <= `RPIS_OUT_RESET;
            end
        end else begin
            in_ff  <= nxt_in;
            out_ff <= nxt_out;
        end
    end

    // -------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------
    logic [15:0] rdata_ff;   // read data
    logic [15:0] nxt_rdata;

    // unmapped addresses and idle cycles return zero
    always_comb begin
        nxt_rdata = '0;
        if (rd_i) begin
            if (in_hit) begin
                nxt_rdata = in_ff[in_idx];
            end else if (out_hit) begin
                nxt_rdata = out_ff[out_idx];
            end else if (osc_hit) begin
                nxt_rdata[`RPIS_LOCK_BIT] = lock_ff;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // -------------------------------------------------------------------
    // input routing
    // -------------------------------------------------------------------
    rpis_pkg::rpis_sel_t in_sel [14];   // selection per peripheral input

    always_comb begin
        in_sel[0]  = field(in_ff[`RPIS_IDX_INT1], 1'b1);
        in_sel[1]  = field(in_ff[`RPIS_IDX_INT32], 1'b0);
        in_sel[2]  = field(in_ff[`RPIS_IDX_INT32], 1'b1);
        in_sel[3]  = field(in_ff[`RPIS_IDX_INT4], 1'b0);
        in_sel[4]  = field(in_ff[`RPIS_IDX_TMR32], 1'b0);
        in_sel[5]  = field(in_ff[`RPIS_IDX_TMR32], 1'b1);
        in_sel[6]  = field(in_ff[`RPIS_IDX_TMR54], 1'b0);
        in_sel[7]  = field(in_ff[`RPIS_IDX_TMR54], 1'b1);
        in_sel[8]  = field(in_ff[`RPIS_IDX_CAP21], 1'b0);
        in_sel[9]  = field(in_ff[`RPIS_IDX_CAP21], 1'b1);
        in_sel[10] = field(in_ff[`RPIS_IDX_CAP43], 1'b0);
        in_sel[11] = field(in_ff[`RPIS_IDX_CAP43], 1'b1);
        in_sel[12] = field(in_ff[`RPIS_IDX_UART1], 1'b0);
        in_sel[13] = field(in_ff[`RPIS_IDX_UART1], 1'b1);
    end

    for (genvar g = 0; g < 14; g++) begin : g_route
        rpis_in_route #(
            .PIN_N (PIN_N)
        ) u_route (
            .sys_clk_i (sys_clk_i),
            .srst_i    (srst_i),
            .pins_i    (pin_s2_ff),
            .sel_i     (in_sel[g]),
            .mapped_o  (periph_in_o[g])
        );
    end

    // -------------------------------------------------------------------
    // output routing
    // -------------------------------------------------------------------
    logic [2*OUT_N-1:0] pin_out_ff;   // pin output levels
    logic [2*OUT_N-1:0] nxt_pin_out;
    logic [2*OUT_N-1:0] pin_oe_ff;    // pin output enables
    logic [2*OUT_N-1:0] nxt_pin_oe;

    // even pin in low field, odd pin in high field; code 0 is no output
    always_comb begin
        rpis_pkg::rpis_sel_t code;
        code = '0;
        for (int p = 0; p < 2 * OUT_N; p++) begin
            code           = field(out_ff[p / 2], p[0]);
            nxt_pin_oe[p]  = code != `RPIS_FN_NULL;
            nxt_pin_out[p] = nxt_pin_oe[p] & periph_out_i[code];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_out_ff <= '0;
            pin_oe_ff  <= '0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
        end
    end

    assign rdata_o        = rdata_ff;
    assign rp_pin_out_o   = pin_out_ff;
    assign rp_pin_oe_o    = pin_oe_ff;
    assign mapping_lock_o = lock_ff;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    a_locked_frozen: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (wr_i && lock_ff) |=> ($stable(in_ff) && $stable(out_ff)))
        else $error("mapping changed while locked");

    a_open_write: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (wr_i && in_hit && !lock_ff) |=> (in_ff[$past(in_idx)] ==
        ($past(wdata_i) & field_mask(32'($past(in_idx))))))
        else $error("unlocked write not stored");

    a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (rd_i && in_hit) |=>
        ((rdata_o & ~field_mask(32'($past(in_idx)))) == 16'h0000))
        else $error("unimplemented bit read nonzero");

    a_lock_keyed: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        $changed(lock_ff) |-> ($past(key_ff) == rpis_pkg::KEY_GOT_SECOND
        && $past(wr_i) && $past(osc_hit)))
        else $error("lock changed without key sequence");

    a_one_way: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (cfg_s2_ff && once_ff && lock_ff) |=> lock_ff)
        else $error("lock cleared in single session mode");

    a_out_null: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (out_ff[0][5:0] == `RPIS_FN_NULL) |=> !rp_pin_oe_o[0])
        else $error("null output code drives pin");

    a_out_select: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (out_ff[1][5:0] == 6'h03) |=>
        (rp_pin_oe_o[2] && rp_pin_out_o[2] == $past(periph_out_i[3])))
        else $error("pin 2 does not follow selected output");
endmodule : rpis_top

`default_nettype wire

// ==== test/rpis_far_model.sv ====
// far side model: remappable pin levels and peripheral output functions
`timescale 1ns/100ps
`default_nettype none

module rpis_far_model (
    input  wire logic        sys_clk_i,    // system clock
    input  wire logic [43:0] pin_set_i,    // pin levels the bench wants
    input  wire logic [63:0] fn_set_i,     // function levels wanted
    output logic      [43:0] rp_pin_o,     // pin levels to the block
    output logic      [63:0] periph_out_o  // peripheral outputs to block
);
    // ------------------------------------------------------------------
    // pins and peripherals move just after an edge, like real logic;
    // the pins are asynchronous to the block, so one extra flop here
    // only shifts the latency and keeps races out of the bench
    // ------------------------------------------------------------------
    initial begin
        rp_pin_o     = 44'h0;
        periph_out_o = 64'h0;
    end

    always @(posedge sys_clk_i) begin
        rp_pin_o     <= pin_set_i;   // pad levels
        periph_out_o <= fn_set_i;    // same clock domain as the block
    end
endmodule : rpis_far_model
`default_nettype wire

// ==== test/rpis_top_tb.sv ====
// self-checking bench of the remappable pin select block
`timescale 1ns/100ps
`default_nettype none
`include "rpis_defines.svh"

module rpis_top_tb;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        sys_clk_i;      // 20 MHz clock
    logic        srst_i;         // sync reset
    logic [6:0]  addr_i;         // bus address
    logic [15:0] wdata_i;        // bus write data
    logic        wr_i;           // write strobe
    logic        rd_i;           // read strobe
    logic        one_session_i;  // single session config
    logic [15:0] rdata_o;        // read data
    logic [13:0] periph_in_o;    // routed inputs
    logic [31:0] rp_pin_out_o;   // pin output levels
    logic [31:0] rp_pin_oe_o;    // pin output enables
    logic        mapping_lock_o; // lock bit
    logic [43:0] rp_pin;         // model pins
    logic [63:0] periph_out;     // model functions
    logic [43:0] pin_set;        // bench pin wish
    logic [63:0] fn_set;         // bench function wish
    int          bad_count;      // mismatches
    int          comparisons;    // checks made

    // one table row: address, reset value, write value, read-back
    typedef struct packed {
        logic [6:0]  addr;
        logic [15:0] rst_val;
        logic [15:0] wval;
        logic [15:0] rd_val;
    } rpis_row_t;
    rpis_row_t rows [12];

    // ------------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------------
    rpis_top u_dut (
        .sys_clk_i      (sys_clk_i),
        .srst_i         (srst_i),
        .addr_i         (addr_i),
        .wdata_i        (wdata_i),
        .wr_i           (wr_i),
        .rd_i           (rd_i),
        .rdata_o        (rdata_o),
        .one_session_i  (one_session_i),
        .rp_pin_i       (rp_pin),
        .periph_out_i   (periph_out),
        .periph_in_o    (periph_in_o),
        .rp_pin_out_o   (rp_pin_out_o),
        .rp_pin_oe_o    (rp_pin_oe_o),
        .mapping_lock_o (mapping_lock_o)
    );

    rpis_far_model u_far (
        .sys_clk_i    (sys_clk_i),
        .pin_set_i    (pin_set),
        .fn_set_i     (fn_set),
        .rp_pin_o     (rp_pin),
        .periph_out_o (periph_out)
    );

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one write cycle, then the strobe drops for a cycle
    task automatic bus_wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask : bus_wr

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [6:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk("read data", exp, rdata_o);
    endtask : bus_rd

    // both key bytes, then the lock-changing write
    task automatic key_seq(input logic [15:0] last);
        bus_wr(`RPIS_OSC_ADDR, {8'h00, `RPIS_KEY_FIRST});
        bus_wr(`RPIS_OSC_ADDR, {8'h00, `RPIS_KEY_SECOND});
        bus_wr(`RPIS_OSC_ADDR, last);
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask : key_seq

    task automatic lock_chk(input logic exp);
        chk("lock bit", {15'h0, exp}, {15'h0, mapping_lock_o});
    endtask : lock_chk

    // model flop plus two sync flops plus route flop, then margin
    task automatic pins_chk(input logic [43:0] lv, input logic [13:0] exp);
        @(posedge sys_clk_i);
        pin_set <= lv;
        repeat (5) @(posedge sys_clk_i);
        #1;
        chk("routed inputs", {2'h0, exp}, {2'h0, periph_in_o});
    endtask : pins_chk

    task automatic out_chk(input logic [63:0] fn, input logic [15:0] exp);
        @(posedge sys_clk_i);
        fn_set <= fn;
        repeat (3) @(posedge sys_clk_i);
        #1;
        chk("pin outputs", exp, rp_pin_out_o[15:0]);
        chk("pin enables", 16'h000C, rp_pin_oe_o[15:0]);
        // upper pins keep the null code, so they must stay released
        chk("upper outputs", 16'h0000, rp_pin_out_o[31:16]);
        chk("upper enables", 16'h0000, rp_pin_oe_o[31:16]);
    endtask : out_chk

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // clock and watchdog; the run needs well under a thousand cycles
    // ------------------------------------------------------------------
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        repeat (3000) @(posedge sys_clk_i);
        bad_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        srst_i = 1'b1;
        addr_i = 7'h00;
        wdata_i = 16'h0000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        one_session_i = 1'b0;
        pin_set = 44'h0;
        fn_set = 64'h0;
        bad_count = 0;
        comparisons = 0;
        // address, reset value, written, read back
        rows = '{'{7'h00, 16'h3F00, 16'hFFFF, 16'h3F00},
                 '{7'h01, 16'h3F3F, 16'h2B2C, 16'h2B2C},
                 '{7'h02, 16'h003F, 16'hFFFF, 16'h003F},
                 '{7'h03, 16'h3F3F, 16'hC102, 16'h0102},
                 '{7'h04, 16'h3F3F, 16'h3F05, 16'h3F05},
                 '{7'h07, 16'h3F3F, 16'h0A0B, 16'h0A0B},
                 '{7'h08, 16'h3F3F, 16'hEAFE, 16'h2A3E},
                 '{7'h12, 16'h3F3F, 16'h0100, 16'h0100},
                 '{7'h21, 16'h0000, 16'h0403, 16'h0403},
                 '{7'h14, 16'h3F3F, 16'h1111, 16'h1111},
                 '{7'h15, 16'h0000, 16'hFFFF, 16'h0000},
                 '{7'h7F, 16'h0000, 16'hFFFF, 16'h0000}};
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        #1;
        lock_chk(1'b0);
        bus_rd(`RPIS_OSC_ADDR, 16'h0000);
        foreach (rows[i]) begin
            bus_rd(rows[i].addr, rows[i].rst_val);
            bus_wr(rows[i].addr, rows[i].wval);
            bus_rd(rows[i].addr, rows[i].rd_val);
        end
        // field values picked so that some exceed 43 and stay unmapped
        pins_chk({44{1'b1}}, 14'h3B74);
        pins_chk(44'h0, 14'h0000);
        pins_chk(44'h1, 14'h1000);
        out_chk(64'h8, 16'h0004);
        out_chk(64'h10, 16'h0008);
        // lock, then a locked write must leave the register alone
        key_seq(16'h0040);
        lock_chk(1'b1);
        bus_rd(`RPIS_OSC_ADDR, 16'h0040);
        bus_wr(7'h01, 16'h0000);
        bus_rd(7'h01, 16'h2B2C);
        // another write between the keys spoils the sequence
        bus_wr(`RPIS_OSC_ADDR, {8'h00, `RPIS_KEY_FIRST});
        bus_wr(7'h01, 16'h0000);
        bus_wr(`RPIS_OSC_ADDR, {8'h00, `RPIS_KEY_SECOND});
        bus_wr(`RPIS_OSC_ADDR, 16'h00BF);
        repeat (2) @(posedge sys_clk_i);
        #1;
        lock_chk(1'b1);
        key_seq(16'h00BF);
        lock_chk(1'b0);
        bus_wr(7'h01, 16'h0505);
        bus_rd(7'h01, 16'h0505);
        // single session: once locked, clearing is refused
        @(posedge sys_clk_i);
        one_session_i <= 1'b1;
        key_seq(16'h0040);
        key_seq(16'h00BF);
        lock_chk(1'b1);
        bus_wr(7'h02, 16'h0000);
        bus_rd(7'h02, 16'h003F);
        // reset in mid-run frees the lock and restores the fields
        @(posedge sys_clk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        lock_chk(1'b0);
        bus_rd(7'h01, 16'h3F3F);
        report_and_stop();
    end
endmodule : rpis_top_tb
`default_nettype wire
